// ---- ga_defines.vh ----
// Function
// - Six alarms, each with its own status latch: two thermal, two voltage, two charge.
// - An alarm works only once its enable bit or detection threshold is set.
// - A disabled alarm ignores its condition; an enabled one latches it.
// - Level alarms clear their latch as soon as the condition is gone.
// - With interrupt enable set, any level latch change sets the event latch.
// - A latch already set when interrupt enable rises raises no event.
// - Event latch and attention pin clear only by a host event register read.
// - Clearing an interrupt enable leaves event latch and attention pin unchanged.
// - With no detection threshold set, clearing an alarm enable clears that alarm's status latch immediately.
// - The charge-change latch is sticky until the host writes zero to it.
// - The charge-change event is raised only on its latch rising.
// - A read clearing the charge-change event also clears its status latch.
// - The device answers as a two-wire bus target at address 7'b1010101.
// - Fast-mode transfers up to 400kb/s; the host keeps within that rate.
`ifndef GA_DEFINES_VH
`define GA_DEFINES_VH
// ==========================================================================
// Bus target address and register offsets.
`define GA_TARGET_ADDR       7'h55
`define GA_OFF_MAIN_CONTROL  8'h00
`define GA_OFF_CURRENT       8'h04
`define GA_OFF_PACK_THERMAL  8'h06
`define GA_OFF_CELL_VOLTAGE  8'h08
`define GA_OFF_STATUS_ONE    8'h0a
`define GA_OFF_STATUS_TWO    8'h0c
`define GA_OFF_REMAINING     8'h10
`define GA_OFF_FULL_CAP      8'h12
`define GA_OFF_MEAN_CURRENT  8'h14
`define GA_OFF_TIME_EMPTY    8'h16
`define GA_OFF_REVISION      8'h20
`define GA_OFF_COMP_A        8'h24
`define GA_OFF_COMP_B        8'h26
`define GA_OFF_DIE_THERMAL   8'h28
`define GA_OFF_LOOP_COUNT    8'h2a
`define GA_OFF_CHARGE_PCT    8'h2c
`define GA_OFF_HEALTH_PCT    8'h2e
`define GA_OFF_STATUS_THREE  8'h30
`define GA_OFF_EVENTS        8'h36
`define GA_OFF_DESIGN_CAP    8'h3c
`define GA_OFF_EXT_SETUP     8'h3e
`define GA_OFF_MEAN_VOLTAGE  8'h64
`define GA_OFF_MEAN_THERMAL  8'h66
// ==========================================================================
// Reset values.
`define GA_RST_ZERO          16'h0000
`define GA_RST_THERMAL       16'h0ba6
`define GA_RST_VOLTAGE       16'h0ed8
`define GA_RST_REMAINING     16'h03cf
`define GA_RST_CAPACITY      16'h079e
`define GA_RST_TIME_EMPTY    16'hffff
`define GA_RST_COMP          16'h3232
`define GA_RST_CHARGE_PCT    16'h0021
`define GA_RST_HEALTH_PCT    16'h0064
// ==========================================================================
// Alarm field layout.
`define GA_NUM_ALARMS        6
`define GA_IDX_CHARGE_CHANGE 5
`define GA_ALARM_EN_LSB      0
`define GA_IRQ_EN_LSB        8
`endif

// ---- ga_i2c_target.v ----
`include "ga_defines.vh"
module ga_i2c_target (
   input  wire       i_clk,
   input  wire       i_resetn,
   input  wire       i_scl,
   input  wire       i_sda,
   output wire       o_sda,
   output wire       o_sda_oe_n,
   output reg  [7:0] o_addr,
   output reg        o_wr,
   output reg  [7:0] o_wr_data,
   output reg        o_rd,
   input  wire [7:0] i_rd_data
);
   localparam [3:0] ST_IDLE = 4'h0, ST_DEV = 4'h1, ST_DEV_ACK = 4'h2, ST_PTR = 4'h3;
   localparam [3:0] ST_PTR_ACK = 4'h4, ST_WDAT = 4'h5, ST_WACK = 4'h6, ST_RDAT = 4'h7;
   localparam [3:0] ST_RACK = 4'h8, ST_HOLD = 4'h9;
   reg  [3:0] state;
   reg        scl_q;
   reg        sda_q;
   reg  [2:0] bit_cnt;
   reg  [7:0] shift;
   reg        sda_low;
   wire       start = i_scl & scl_q & sda_q & ~i_sda;
   wire       stop  = i_scl & scl_q & ~sda_q & i_sda;
   wire       rise  = i_scl & ~scl_q;
   wire       fall  = ~i_scl & scl_q;
   assign o_sda      = 1'b0;
   assign o_sda_oe_n = ~sda_low;
   // ========================================================================
   // Bit engine and transfer sequencing.
   always @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         state     <= ST_IDLE;
         scl_q     <= 1'b1;
         sda_q     <= 1'b1;
         bit_cnt   <= 3'h0;
         shift     <= 8'h00;
         sda_low   <= 1'b0;
         o_addr    <= 8'h00;
         o_wr      <= 1'b0;
         o_wr_data <= 8'h00;
         o_rd      <= 1'b0;
      end else begin
         scl_q <= i_scl;
         sda_q <= i_sda;
         o_wr  <= 1'b0;
         o_rd  <= 1'b0;
         if (start) begin
            state   <= ST_HOLD;
            bit_cnt <= 3'h0;
            sda_low <= 1'b0;
         end else if (stop) begin
            state   <= ST_IDLE;
            sda_low <= 1'b0;
         end else if (rise) begin
            bit_cnt <= bit_cnt + 3'h1;
            if (state == ST_DEV || state == ST_PTR || state == ST_WDAT) begin
               shift <= {shift[6:0], i_sda};
            end
            if (state == ST_RACK && i_sda) begin
               state <= ST_IDLE;
            end
         end else if (fall) begin
            case (state)
               ST_DEV, ST_PTR, ST_WDAT: begin
                  if (bit_cnt == 3'h0) begin
                     if (state != ST_DEV || shift[7:1] == `GA_TARGET_ADDR) begin
                        sda_low <= 1'b1;
                        state   <= state + 4'h1;
                     end else begin
                        state <= ST_IDLE;
                     end
                     if (state == ST_PTR) begin
                        o_addr <= shift;
                     end
                     if (state == ST_WDAT) begin
                        o_wr      <= 1'b1;
                        o_wr_data <= shift;
                     end
                  end
               end
               ST_DEV_ACK: begin
                  bit_cnt <= 3'h0;
                  if (shift[0]) begin
                     shift   <= i_rd_data;
                     o_rd    <= 1'b1;
                     sda_low <= ~i_rd_data[7];
                     state   <= ST_RDAT;
                  end else begin
                     sda_low <= 1'b0;
                     state   <= ST_PTR;
                  end
               end
               ST_PTR_ACK: begin
                  bit_cnt <= 3'h0;
                  sda_low <= 1'b0;
                  state   <= ST_WDAT;
               end
               ST_WACK: begin
                  bit_cnt <= 3'h0;
                  sda_low <= 1'b0;
                  o_addr  <= o_addr + 8'h01;
                  state   <= ST_WDAT;
               end
               ST_RDAT: begin
                  if (bit_cnt == 3'h0) begin
                     sda_low <= 1'b0;
                     o_addr  <= o_addr + 8'h01;
                     state   <= ST_RACK;
                  end else begin
                     shift   <= {shift[6:0], 1'b0};
                     sda_low <= ~shift[6];
                  end
               end
               ST_RACK: begin
                  bit_cnt <= 3'h0;
                  shift   <= i_rd_data;
                  o_rd    <= 1'b1;
                  sda_low <= ~i_rd_data[7];
                  state   <= ST_RDAT;
               end
               ST_HOLD: begin
                  state <= ST_DEV;
               end
               default: begin
                  sda_low <= 1'b0;
               end
            endcase
         end
      end
   end
   // The pointer steps at the end of each read byte, ahead of the next fetch.
endmodule // ga_i2c_target

// ---- ga_gauge_alert.v ----
`include "ga_defines.vh"
module ga_gauge_alert #(
   // Arbitrary neutral revision value.
   parameter [15:0] REVISION = 16'h00a5
) (
   input  wire        i_clk,
   input  wire        i_resetn,
   input  wire        i_scl,
   input  wire        i_sda,
   output wire        o_sda,
   output wire        o_sda_oe_n,
   output reg         o_alert_n,
   input  wire [5:0]  i_alarm_cond,
   input  wire [5:0]  i_thresh_set,
   input  wire        i_meas_update,
   input  wire [15:0] i_current,
   input  wire [15:0] i_pack_thermal,
   input  wire [15:0] i_cell_voltage,
   input  wire [15:0] i_status_one,
   input  wire [15:0] i_status_two,
   input  wire [15:0] i_remaining,
   input  wire [15:0] i_full_cap,
   input  wire [15:0] i_mean_current,
   input  wire [15:0] i_time_empty,
   input  wire [15:0] i_die_thermal,
   input  wire [15:0] i_charge_pct,
   input  wire [15:0] i_health_pct,
   input  wire [15:0] i_mean_voltage,
   input  wire [15:0] i_mean_thermal,
   input  wire        i_loop_inc,
   output wire [15:0] o_main_control,
   output wire [15:0] o_comp_a,
   output wire [15:0] o_comp_b
);
   // ========================================================================
   // Register storage.
   reg  [15:0] main_control;
   reg  [15:0] comp_a;
   reg  [15:0] comp_b;
   reg  [15:0] loop_count;
   reg  [15:0] ext_setup;
   reg  [15:0] battery_current;
   reg  [15:0] pack_thermal;
   reg  [15:0] cell_voltage;
   reg  [15:0] status_one;
   reg  [15:0] status_two;
   reg  [15:0] remaining;
   reg  [15:0] full_cap;
   reg  [15:0] mean_current;
   reg  [15:0] time_empty;
   reg  [15:0] die_thermal;
   reg  [15:0] charge_pct;
   reg  [15:0] health_pct;
   reg  [15:0] mean_voltage;
   reg  [15:0] mean_thermal;
   reg  [5:0]  alarm_flag;
   reg  [5:0]  event_latch;
   wire [5:0]  next_flag;
   wire [5:0]  next_event;
   wire [7:0]  bus_addr;
   wire        bus_wr;
   wire [7:0]  bus_wr_data;
   wire        bus_rd;
   reg  [15:0] rd_word;
   wire [7:0]  rd_byte;
   wire [7:0]  word_addr;
   wire        hi_byte;
   assign o_main_control = main_control;
   assign o_comp_a       = comp_a;
   assign o_comp_b       = comp_b;
   assign word_addr      = {bus_addr[7:1], 1'b0};
   assign hi_byte        = bus_addr[0];
   // ========================================================================
   // Two-wire bus target.
   ga_i2c_target u_target (
      .i_clk      (i_clk),
      .i_resetn   (i_resetn),
      .i_scl      (i_scl),
      .i_sda      (i_sda),
      .o_sda      (o_sda),
      .o_sda_oe_n (o_sda_oe_n),
      .o_addr     (bus_addr),
      .o_wr       (bus_wr),
      .o_wr_data  (bus_wr_data),
      .o_rd       (bus_rd),
      .i_rd_data  (rd_byte)
   );
   // ========================================================================
   // Read data selection.
   always @* begin
      case (word_addr)
         `GA_OFF_MAIN_CONTROL: begin
            rd_word = main_control;
         end
         `GA_OFF_CURRENT: begin
            rd_word = battery_current;
         end
         `GA_OFF_PACK_THERMAL: begin
            rd_word = pack_thermal;
         end
         `GA_OFF_CELL_VOLTAGE: begin
            rd_word = cell_voltage;
         end
         `GA_OFF_STATUS_ONE: begin
            rd_word = status_one;
         end
         `GA_OFF_STATUS_TWO: begin
            rd_word = status_two;
         end
         `GA_OFF_REMAINING: begin
            rd_word = remaining;
         end
         `GA_OFF_FULL_CAP: begin
            rd_word = full_cap;
         end
         `GA_OFF_MEAN_CURRENT: begin
            rd_word = mean_current;
         end
         `GA_OFF_TIME_EMPTY: begin
            rd_word = time_empty;
         end
         `GA_OFF_REVISION: begin
            rd_word = REVISION;
         end
         `GA_OFF_COMP_A: begin
            rd_word = comp_a;
         end
         `GA_OFF_COMP_B: begin
            rd_word = comp_b;
         end
         `GA_OFF_DIE_THERMAL: begin
            rd_word = die_thermal;
         end
         `GA_OFF_LOOP_COUNT: begin
            rd_word = loop_count;
         end
         `GA_OFF_CHARGE_PCT: begin
            rd_word = charge_pct;
         end
         `GA_OFF_HEALTH_PCT: begin
            rd_word = health_pct;
         end
         `GA_OFF_STATUS_THREE: begin
            rd_word = {10'h000, alarm_flag};
         end
         `GA_OFF_EVENTS: begin
            rd_word = {10'h000, event_latch};
         end
         `GA_OFF_DESIGN_CAP: begin
            rd_word = `GA_RST_CAPACITY;
         end
         `GA_OFF_EXT_SETUP: begin
            rd_word = ext_setup;
         end
         `GA_OFF_MEAN_VOLTAGE: begin
            rd_word = mean_voltage;
         end
         `GA_OFF_MEAN_THERMAL: begin
            rd_word = mean_thermal;
         end
         default: begin
            rd_word = `GA_RST_ZERO;
         end
      endcase
   end
   assign rd_byte = hi_byte ? rd_word[15:8] : rd_word[7:0];
   // ========================================================================
   // Host-writable registers.
   always @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         main_control <= `GA_RST_ZERO;
         comp_a       <= `GA_RST_COMP;
         comp_b       <= `GA_RST_COMP;
         loop_count   <= `GA_RST_ZERO;
         ext_setup    <= `GA_RST_ZERO;
      end else begin
         if (i_loop_inc) begin
            loop_count <= loop_count + 16'h0001;
         end
         if (bus_wr) begin
            case (word_addr)
               `GA_OFF_MAIN_CONTROL: begin
                  if (hi_byte) begin
                     main_control[15:8] <= bus_wr_data;
                  end else begin
                     main_control[7:0] <= bus_wr_data;
                  end
               end
               `GA_OFF_COMP_A: begin
                  if (hi_byte) begin
                     comp_a[15:8] <= bus_wr_data;
                  end else begin
                     comp_a[7:0] <= bus_wr_data;
                  end
               end
               `GA_OFF_COMP_B: begin
                  if (hi_byte) begin
                     comp_b[15:8] <= bus_wr_data;
                  end else begin
                     comp_b[7:0] <= bus_wr_data;
                  end
               end
               `GA_OFF_LOOP_COUNT: begin
                  if (hi_byte) begin
                     loop_count[15:8] <= bus_wr_data;
                  end else begin
                     loop_count[7:0] <= bus_wr_data;
                  end
               end
               `GA_OFF_EXT_SETUP: begin
                  if (hi_byte) begin
                     ext_setup[15:8] <= bus_wr_data;
                  end else begin
                     ext_setup[7:0] <= bus_wr_data;
                  end
               end
               default: begin
                  main_control <= main_control;
               end
            endcase
         end
      end
   end
   // ========================================================================
   // Measurement snapshots from the gauging core.
   always @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         battery_current <= `GA_RST_ZERO;
         pack_thermal    <= `GA_RST_THERMAL;
         cell_voltage    <= `GA_RST_VOLTAGE;
         status_one      <= `GA_RST_ZERO;
         status_two      <= `GA_RST_ZERO;
         remaining       <= `GA_RST_REMAINING;
         full_cap        <= `GA_RST_CAPACITY;
         mean_current    <= `GA_RST_ZERO;
         time_empty      <= `GA_RST_TIME_EMPTY;
         die_thermal     <= `GA_RST_THERMAL;
         charge_pct      <= `GA_RST_CHARGE_PCT;
         health_pct      <= `GA_RST_HEALTH_PCT;
         mean_voltage    <= `GA_RST_VOLTAGE;
         mean_thermal    <= `GA_RST_THERMAL;
      end else if (i_meas_update) begin
         battery_current <= i_current;
         pack_thermal    <= i_pack_thermal;
         cell_voltage    <= i_cell_voltage;
         status_one      <= i_status_one;
         status_two      <= i_status_two;
         remaining       <= i_remaining;
         full_cap        <= i_full_cap;
         mean_current    <= i_mean_current;
         time_empty      <= i_time_empty;
         die_thermal     <= i_die_thermal;
         charge_pct      <= i_charge_pct;
         health_pct      <= i_health_pct;
         mean_voltage    <= i_mean_voltage;
         mean_thermal    <= i_mean_thermal;
      end
   end
   // ========================================================================
   // Alarm status and event latches.
   wire evt_read = bus_rd && bus_addr == `GA_OFF_EVENTS;
   wire flag_wr  = bus_wr && bus_addr == `GA_OFF_STATUS_THREE;
   wire cc_write_zero = flag_wr && !bus_wr_data[`GA_IDX_CHARGE_CHANGE];
   wire cc_read_clear = evt_read && event_latch[`GA_IDX_CHARGE_CHANGE];
   genvar k;
   generate
      for (k = 0; k < `GA_NUM_ALARMS; k = k + 1) begin : g_alarm
         wire enabled = ext_setup[`GA_ALARM_EN_LSB + k] | i_thresh_set[k];
         wire irq_en  = ext_setup[`GA_IRQ_EN_LSB + k];
         wire evt_set;
         if (k == `GA_IDX_CHARGE_CHANGE) begin : g_sticky
            wire clr = cc_write_zero | cc_read_clear;
            // Sticky latch; a new condition wins over a clear in the same cycle.
            assign next_flag[k] = enabled & (i_alarm_cond[k] | (alarm_flag[k] & ~clr));
            assign evt_set = irq_en & ~alarm_flag[k] & next_flag[k];
         end else begin : g_level
            assign next_flag[k] = enabled & i_alarm_cond[k];
            assign evt_set = irq_en & (alarm_flag[k] ^ next_flag[k]);
         end
         // Only a read clears the event; interrupt enable never does.
         assign next_event[k] = evt_set | (event_latch[k] & ~evt_read);
      end
   endgenerate
   always @(posedge i_clk or negedge i_resetn) begin
      if (!i_resetn) begin
         alarm_flag  <= 6'h00;
         event_latch <= 6'h00;
         o_alert_n   <= 1'b1;
      end else begin
         alarm_flag  <= next_flag;
         event_latch <= next_event;
         o_alert_n   <= ~(|next_event);
      end
   end
endmodule // ga_gauge_alert

// ---- ga_host_model.sv ----
module ga_host_model #(
   parameter int HALF = 12
) (
   input  wire  i_clk,
   input  wire  i_sda,
   output logic o_scl,
   output logic o_sda_low
);
   timeunit 1ns;
   timeprecision 1ns;
   // =====================================================================
   // Bus primitives: the data line is pulled low or released, never driven.
   initial begin
      o_scl = 1'b1;
      o_sda_low = 1'b0;
   end
   task automatic tick(input int n);
      repeat (n) @(posedge i_clk);
   endtask
   task automatic start();
      o_sda_low <= 1'b0;
      tick(HALF);
      o_scl <= 1'b1;
      tick(HALF);
      o_sda_low <= 1'b1;
      tick(HALF);
      o_scl <= 1'b0;
      tick(HALF);
   endtask
   task automatic stop();
      o_sda_low <= 1'b1;
      tick(HALF);
      o_scl <= 1'b1;
      tick(HALF);
      o_sda_low <= 1'b0;
      tick(HALF);
   endtask
   task automatic xfer(input logic [7:0] d, input logic ao, output logic [7:0] r,
                       output logic ai);
      logic [8:0] s;
      s = {d, ao};
      for (int i = 8; i >= 0; i--) begin
         o_sda_low <= ~s[i];
         tick(HALF);
         o_scl <= 1'b1;
         tick(HALF);
         s[i] = i_sda;
         o_scl <= 1'b0;
         tick(1);
      end
      r = s[8:1];
      ai = s[0];
   endtask
   // =====================================================================
   // Word transfers: low byte first, pointer sent after the address.
   task automatic wr(input logic [6:0] ta, input logic [7:0] p, input logic [15:0] d,
                     output logic ak);
      logic [7:0] r;
      logic       a;
      start();
      xfer({ta, 1'b0}, 1'b1, r, ak);
      xfer(p, 1'b1, r, a);
      xfer(d[7:0], 1'b1, r, a);
      xfer(d[15:8], 1'b1, r, a);
      stop();
   endtask
   task automatic rd(input logic [6:0] ta, input logic [7:0] p, output logic [15:0] d,
                     output logic ak);
      logic a;
      start();
      xfer({ta, 1'b0}, 1'b1, d[7:0], ak);
      xfer(p, 1'b1, d[7:0], a);
      start();
      xfer({ta, 1'b1}, 1'b1, d[7:0], a);
      xfer(8'hff, 1'b0, d[7:0], a);
      xfer(8'hff, 1'b1, d[15:8], a);
      stop();
   endtask
endmodule // ga_host_model

// ---- ga_gauge_alert_asserts.sv ----
module ga_gauge_alert_asserts (
   input wire        i_clk,
   input wire        i_resetn,
   input wire        i_scl,
   input wire [5:0]  i_alarm_cond,
   input wire [5:0]  i_thresh_set,
   input wire        o_sda,
   input wire        o_sda_oe_n,
   input wire        o_alert_n,
   input wire [15:0] o_main_control,
   input wire [15:0] o_comp_a,
   input wire [15:0] o_comp_b
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (!i_resetn);
   // =====================================================================
   // Attention pin and bus pin relations.
   rst_idle_out_a: assert property ($rose(i_resetn) |-> o_alert_n && o_sda_oe_n)
      else $error("outputs not idle after reset");
   alert_fall_cause_a: assert property (
      $fell(o_alert_n) |-> !i_scl || $past(i_alarm_cond) != $past(i_alarm_cond, 3)
      || $past(i_thresh_set) != $past(i_thresh_set, 3))
      else $error("attention fell without cause");
   alert_hold_idle_a: assert property (!o_alert_n && i_scl |=> !o_alert_n)
      else $error("attention released outside a read");
   alert_low_span_a: assert property ($fell(o_alert_n) |-> !o_alert_n [*3])
      else $error("attention pulse too short");
   sda_change_low_a: assert property ($changed(o_sda_oe_n) |-> !$past(i_scl))
      else $error("data pin changed while clock high");
   sda_drive_zero_a: assert property ($fell(o_sda_oe_n) |-> !o_sda ##[1:400] o_sda_oe_n)
      else $error("data pin driven high");
   reg_write_ack_a: assert property (
      $changed({o_main_control, o_comp_a, o_comp_b}) |-> !o_sda_oe_n && !i_scl)
      else $error("register changed outside write ack");
   ctrl_idle_hold_a: assert property (i_scl [*2] |=> $stable(o_main_control))
      else $error("control changed while bus idle");
   alert_fall_c: cover property ($fell(o_alert_n));
   alert_rise_c: cover property ($rose(o_alert_n));
   comp_write_c: cover property ($changed(o_comp_a));
endmodule // ga_gauge_alert_asserts

// ---- testbench.sv ----
`include "ga_defines.vh"
module testbench;
   timeunit 1ns;
   timeprecision 1ns;
   localparam logic [15:0] REV = 16'h5a3c; // Arbitrary revision value.
   logic        i_clk;
   logic        i_resetn;
   logic        scl;
   logic        sda_low;
   wire         sda;
   wire         o_sda;
   wire         o_sda_oe_n;
   wire         o_alert_n;
   wire  [15:0] o_main_control;
   wire  [15:0] o_comp_a;
   wire  [15:0] o_comp_b;
   logic [5:0]  cond;
   logic [5:0]  thr;
   logic        upd;
   logic        inc;
   logic [15:0] meas;
   logic [15:0] v;
   logic        ak;
   int          n_mismatch = 0;
   int          total_checks = 0;
   int          cycles = 0;
   logic [7:0]  offs [24] = '{8'h00, 8'h04, 8'h06, 8'h08, 8'h0a, 8'h0c, 8'h10, 8'h12,
      8'h14, 8'h16, 8'h20, 8'h24, 8'h26, 8'h28, 8'h2a, 8'h2c, 8'h2e, 8'h30, 8'h36,
      8'h3c, 8'h3e, 8'h64, 8'h66, 8'h02};
   logic [15:0] rstv [24] = '{16'h0000, 16'h0000, 16'h0ba6, 16'h0ed8, 16'h0000,
      16'h0000, 16'h03cf, 16'h079e, 16'h0000, 16'hffff, REV, 16'h3232, 16'h3232,
      16'h0ba6, 16'h0000, 16'h0021, 16'h0064, 16'h0000, 16'h0000, 16'h079e, 16'h0000,
      16'h0ed8, 16'h0ba6, 16'h0000};
   assign sda = ~(sda_low | (~o_sda_oe_n & ~o_sda));
   ga_gauge_alert #(.REVISION(REV)) ga_gauge_alert_i (
      .i_clk, .i_resetn, .i_scl(scl), .i_sda(sda), .o_sda, .o_sda_oe_n, .o_alert_n,
      .i_alarm_cond(cond), .i_thresh_set(thr), .i_meas_update(upd), .i_current(meas),
      .i_pack_thermal(meas), .i_cell_voltage(meas), .i_status_one(meas),
      .i_status_two(meas), .i_remaining(meas), .i_full_cap(meas),
      .i_mean_current(meas), .i_time_empty(meas), .i_die_thermal(meas),
      .i_charge_pct(meas), .i_health_pct(meas), .i_mean_voltage(meas),
      .i_mean_thermal(meas), .i_loop_inc(inc), .o_main_control, .o_comp_a, .o_comp_b);
   ga_host_model ga_host_model_i (.i_clk, .i_sda(sda), .o_scl(scl), .o_sda_low(sda_low));
   // =====================================================================
   // Clock, timeout and shared tasks.
   initial begin
      i_clk = 1'b0;
      forever #50 i_clk = ~i_clk;
   end
   always @(posedge i_clk) begin
      cycles <= cycles + 1;
      if (cycles == 100000) begin
         n_mismatch++;
         report_and_stop();
      end
   end
   task automatic report_and_stop();
      $display("checks %0d mismatches %0d", total_checks, n_mismatch);
      if (n_mismatch == 0 && total_checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
      total_checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic tk(input int n);
      repeat (n) @(posedge i_clk);
   endtask
   task automatic rdc(input logic [7:0] p, input logic [15:0] exp);
      ga_host_model_i.rd(`GA_TARGET_ADDR, p, v, ak);
      check($sformatf("reg_%h", p), v, exp);
   endtask
   task automatic wr(input logic [7:0] p, input logic [15:0] d);
      ga_host_model_i.wr(`GA_TARGET_ADDR, p, d, ak);
   endtask
   task automatic chk_alert(input logic e);
      check("alert_n", {15'h0000, o_alert_n}, {15'h0000, e});
   endtask
   // =====================================================================
   // Main sequence.
   initial begin
      i_resetn = 1'b0;
      cond = 6'h00;
      thr = 6'h00;
      upd = 1'b0;
      inc = 1'b0;
      meas = 16'h1357;
      tk(5);
      i_resetn <= 1'b1;
      tk(2);
      foreach (offs[k]) rdc(offs[k], rstv[k]);
      chk_alert(1'b1);
      ga_host_model_i.rd(7'h2a, 8'h00, v, ak);
      check("wrong_addr_ack", {15'h0000, ak}, 16'h0001);
      wr(8'h24, 16'habcd);
      check("comp_a_port", o_comp_a, 16'habcd);
      wr(8'h26, 16'h1234);
      check("comp_b_port", o_comp_b, 16'h1234);
      wr(8'h00, 16'h4000);
      check("ctrl_port", o_main_control, 16'h4000);
      wr(8'h04, 16'h5555);
      upd <= 1'b1;
      tk(1);
      upd <= 1'b0;
      rdc(8'h04, 16'h1357);
      rdc(8'h66, 16'h1357);
      wr(8'h2a, 16'h0102);
      inc <= 1'b1;
      tk(1);
      inc <= 1'b0;
      rdc(8'h2a, 16'h0103);
      cond <= 6'h04;
      tk(4);
      rdc(8'h30, 16'h0000);
      chk_alert(1'b1);
      wr(8'h3e, 16'h003f);
      rdc(8'h30, 16'h0004);
      wr(8'h3e, 16'h3f3f);
      chk_alert(1'b1);
      cond <= 6'h00;
      tk(4);
      chk_alert(1'b0);
      rdc(8'h30, 16'h0000);
      wr(8'h3e, 16'h003f);
      chk_alert(1'b0);
      rdc(8'h36, 16'h0004);
      chk_alert(1'b1);
      cond <= 6'h08;
      tk(4);
      rdc(8'h30, 16'h0008);
      wr(8'h3e, 16'h0037);
      rdc(8'h30, 16'h0000);
      cond <= 6'h00;
      wr(8'h3e, 16'h0000);
      thr <= 6'h10;
      cond <= 6'h10;
      tk(4);
      rdc(8'h30, 16'h0010);
      thr <= 6'h00;
      cond <= 6'h00;
      wr(8'h3e, 16'h3f3f);
      for (int i = 0; i < 6; i++) begin
         cond <= 6'h01 << i;
         tk(1);
         if (i == 5)
            cond <= 6'h00;
         tk(3);
         chk_alert(1'b0);
         rdc(8'h30, 16'h0001 << i);
         rdc(8'h36, 16'h0001 << i);
         cond <= 6'h00;
         tk(4);
         rdc(8'h30, 16'h0000);
         rdc(8'h36, (i < 5) ? (16'h0001 << i) : 16'h0000);
      end
      cond <= 6'h20;
      tk(1);
      cond <= 6'h00;
      tk(3);
      wr(8'h30, 16'h0000);
      rdc(8'h30, 16'h0000);
      chk_alert(1'b0);
      rdc(8'h36, 16'h0020);
      chk_alert(1'b1);
      i_resetn <= 1'b0;
      tk(2);
      i_resetn <= 1'b1;
      tk(2);
      check("comp_a_port", o_comp_a, 16'h3232);
      check("ctrl_port", o_main_control, 16'h0000);
      rdc(8'h3e, 16'h0000);
      report_and_stop();
   end
endmodule // testbench
bind ga_gauge_alert ga_gauge_alert_asserts ga_gauge_alert_asserts_i (
   .i_clk, .i_resetn, .i_scl, .i_alarm_cond, .i_thresh_set, .o_sda, .o_sda_oe_n,
   .o_alert_n, .o_main_control, .o_comp_a, .o_comp_b);
